/* File: fprot_array_model.sv */
// flash array model facing the controller's array port
`timescale 1ns/1ns
`include "fprot_defs.svh"

module fprot_array_model
    import fprot_pkg::*;
#(
    parameter int WORDS = 2048,
    parameter int BLOCK_WORDS = 256,
    parameter int MIN_PROG = 20
)
(
    // clock
    input wire logic clk_i,
    // array port
    input wire logic [`FADDR_W-1:0] raddr_i,
    output logic [31:0] rdata_o,
    input wire logic [`FADDR_W-1:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic prog_i,
    input wire logic erase_i,
    // pulse length check
    output logic short_o
);
    logic [31:0] mem [WORDS];
    int unsigned len;
    int ra;
    int wa;

    // ==========================================================
    // array behaviour
    // reads answer in the same cycle; beyond the array word 0 is returned
    // inverted, so a stray read never matches word 0
    assign ra = int'(raddr_i[`FADDR_W-1:2]);
    assign wa = int'(addr_i[`FADDR_W-1:2]);
    assign rdata_o = (ra < WORDS) ? mem[ra] : ~mem[0];

    // cells start cleared so an erase is visible on readback
    initial
    begin
        for (int i = 0; i < WORDS; i++)
            mem[i] = 32'h0000_0000;
        short_o = 1'b0;
        len = 0;
    end

    // a cell can only lose ones while programmed; erase sets a block
    always @(posedge clk_i)
    begin
        if (prog_i && wa < WORDS)
            mem[wa] <= mem[wa] & wdata_i;
        if (erase_i)
            for (int i = 0; i < BLOCK_WORDS; i++)
                if (wa + i < WORDS)
                    mem[wa + i] <= 32'hffff_ffff;
        len <= prog_i ? len + 1 : 0;
        if (!prog_i && len != 0 && len < MIN_PROG)
            short_o <= 1'b1;
    end
endmodule : fprot_array_model

/* File: fprot_ctrl.sv */
// flash controller: erase, word program, block protection and interrupts
// Functional notes
// - erase drives the array to set a whole block to ones
// - erase block size is a build parameter, one or sixteen kilobytes
// - protection is held per two-kilobyte region of paired blocks
// - read-only regions refuse program and erase, allow reads and fetches
// - execute-only regions refuse changes and serve instruction fetches only
// - programming one word only clears bits, zero bits stay zero
// - the same word may be programmed again to clear more bits
// - software loads cycles per microsecond to time array strobes
// - an invalid access raises the access violation source
// - program or erase of a protected block raises the violation source
// - a finished program or erase raises the completion source
// - protection writes take effect at once and are not made permanent
// - erase of a bad address or protected block fails, array unchanged
// - total capacity is a build parameter from 8 to 512 kilobytes
// - writing the clear mask drops the named interrupt sources
// - only enabled sources reach the interrupt line
// - raw and masked status are readable, masked is raw and enable
// - protection only moves stricter, execute-only never changes
`timescale 1ns/1ns
`include "fprot_defs.svh"

module fprot_ctrl
    import fprot_pkg::*;
#(
    parameter int FLASH_KB = `FLASH_KB_DEF,
    parameter int BLOCK_KB = `BLOCK_KB_DEF,
    parameter logic [15:0] ERASE_TIME_US = `ERASE_TIME_US_DEF
)
(
    // clock and reset
    input wire logic clk_i,
    input wire logic srst_i,
    // register port
    input wire logic [7:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_we_i,
    input wire logic reg_re_i,
    output logic [31:0] reg_rdata_o,
    // core reads and fetches
    input wire logic rd_req_i,
    input wire logic [1:0] rd_kind_i,
    input wire logic [`FADDR_W-1:0] rd_addr_i,
    output logic rd_ready_o,
    output logic rd_valid_o,
    output logic rd_err_o,
    output logic [31:0] rd_data_o,
    // flash array
    output logic [`FADDR_W-1:0] arr_raddr_o,
    input wire logic [31:0] arr_rdata_i,
    output logic [`FADDR_W-1:0] arr_addr_o,
    output logic [31:0] arr_wdata_o,
    output logic arr_prog_o,
    output logic arr_erase_o,
    // status
    output logic busy_o,
    output logic irq_o
);

    // ==========================================================
    // geometry derived from the build parameters
    localparam logic [19:0] FLASH_BYTES = 20'(FLASH_KB * 1024);
    localparam logic [`FADDR_W-1:0] BLK_MASK =
        `FADDR_W'(BLOCK_KB * 1024 - 1);
    localparam int RPB = (BLOCK_KB >= 2) ? BLOCK_KB / 2 : 1;
    localparam logic [`REGION_W-1:0] RPB_MASK = `REGION_W'(RPB - 1);

    ctrl_t s;
    ctrl_t next_s;
    logic tmr_done;
    logic prog_req;
    logic erase_req;
    logic prog_bad;
    logic erase_bad;
    logic erase_prot;
    logic prog_go;
    logic rd_take;
    logic prot_ok;
    logic [`REGION_W-1:0] cmd_region;
    logic [`REGION_W-1:0] ers_region;
    prot_t cmd_prot;
    prot_t take_prot;
    prot_t new_prot;
    prot_t rd_prot;

    // address lies inside the built array
    function automatic logic in_range(input logic [`FADDR_W-1:0] a);
        in_range = {1'b0, a} < FLASH_BYTES;
    endfunction : in_range

    // region that holds a byte address
    function automatic logic [`REGION_W-1:0] region_of(
        input logic [`FADDR_W-1:0] a);
        region_of = a[`FADDR_W-1:`REGION_SHIFT];
    endfunction : region_of

    // ==========================================================
    // array strobe timer
    fprot_us_timer u_timer
    (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .start_i(s.tmr_start),
        .cyc_per_us_i(s.usec),
        .us_i(s.tmr_us),
        .done_o(tmr_done)
    );

    // ==========================================================
    // command decode and protection lookups
    assign prog_req = reg_we_i && (reg_addr_i == `REG_CMD)
        && reg_wdata_i[`CMD_PROG];
    assign erase_req = reg_we_i && (reg_addr_i == `REG_CMD)
        && reg_wdata_i[`CMD_ERASE] && !reg_wdata_i[`CMD_PROG];
    assign cmd_region = region_of(s.addr);
    assign cmd_prot = s.prot[cmd_region];
    assign take_prot = s.prot[region_of(rd_addr_i)];
    assign rd_prot = s.prot[region_of(s.raddr)];
    assign ers_region = cmd_region & ~RPB_MASK;
    assign new_prot = prot_t'(reg_wdata_i[1:0]);
    assign prog_bad = !in_range(s.addr) || (cmd_prot != PROT_RW);
    assign erase_bad = !in_range(s.addr) || ((s.addr & BLK_MASK) != '0)
        || erase_prot;
    assign prog_go = (s.state == ST_IDLE) && prog_req && !prog_bad;

    // any region of a large erase block that is not read/write blocks it
    always_comb
    begin
        erase_prot = 1'b0;
        for (int i = 0; i < RPB; i++)
        begin
            if (s.prot[`REGION_W'(ers_region + `REGION_W'(i))] != PROT_RW)
            begin
                erase_prot = 1'b1;
            end
        end
    end

    // only ever tighten; a code of three is no level and is refused
    always_comb
    begin
        prot_ok = 1'b0;
        if (in_range(s.addr) && (reg_wdata_i[1:0] != 2'b11))
        begin
            unique case (cmd_prot)
                PROT_RW: prot_ok = 1'b1;
                PROT_RO: prot_ok = (new_prot != PROT_RW);
                PROT_XO: prot_ok = (new_prot == PROT_XO);
                default: prot_ok = 1'b0;
            endcase
        end
    end

    // the readback cycle owns the array read port, so reads stall there
    assign rd_ready_o = (s.state != ST_RDOLD) && !prog_go;
    assign rd_take = rd_req_i && rd_ready_o;

    // ==========================================================
    // next state
    always_comb
    begin
        next_s = s;
        next_s.tmr_start = 1'b0;
        next_s.rd_valid = 1'b0;
        next_s.rd_err = 1'b0;
        next_s.rd_data = 32'h0000_0000;
        next_s.rdata = 32'h0000_0000;

        // software writes; clears come first so later sets win
        if (reg_we_i)
        begin
            case (reg_addr_i)
                `REG_ADDR: next_s.addr = reg_wdata_i[`FADDR_W-1:0];
                `REG_DATA: next_s.data = reg_wdata_i;
                `REG_USEC: next_s.usec = reg_wdata_i[7:0];
                `REG_IM: next_s.im = reg_wdata_i[1:0];
                `REG_ICR: next_s.ris = s.ris & ~reg_wdata_i[1:0];
                `REG_PROT:
                begin
                    // volatile: lost at the next reset
                    if (prot_ok)
                    begin
                        next_s.prot[cmd_region] = new_prot;
                    end
                    else
                    begin
                        next_s.fail = 1'b1;
                    end
                end
                default: ;
            endcase
        end

        // software reads, answered in the next cycle
        if (reg_re_i)
        begin
            case (reg_addr_i)
                `REG_ADDR: next_s.rdata = 32'(s.addr);
                `REG_DATA: next_s.rdata = s.data;
                `REG_CMD:
                    next_s.rdata = {30'h0000_0000, s.fail,
                        s.state != ST_IDLE};
                `REG_PROT: next_s.rdata = 32'(cmd_prot);
                `REG_USEC: next_s.rdata = 32'(s.usec);
                `REG_RIS: next_s.rdata = 32'(s.ris);
                `REG_IM: next_s.rdata = 32'(s.im);
                `REG_MIS: next_s.rdata = 32'(s.ris & s.im);
                default: next_s.rdata = 32'h0000_0000;
            endcase
        end

        // core read answer: in range, fetches always, data and debug unless exec-only
        if (s.rpend)
        begin
            next_s.rd_valid = 1'b1;
            if (!in_range(s.raddr) || ((rd_prot == PROT_XO)
                && (s.rkind != ACC_FETCH)))
            begin
                next_s.rd_err = 1'b1;
                next_s.ris[`IRQ_ACC] = 1'b1;
            end
            else
            begin
                next_s.rd_data = arr_rdata_i;
            end
        end
        next_s.rpend = rd_take;
        if (rd_take)
        begin
            next_s.raddr = rd_addr_i;
            next_s.rkind = rd_kind_i;
        end

        // sequencer; commands outside idle are dropped
        unique case (s.state)
            ST_IDLE:
            begin
                if (prog_req)
                begin
                    if (prog_bad)
                    begin
                        next_s.fail = 1'b1;
                        if (cmd_prot != PROT_RW)
                        begin
                            next_s.ris[`IRQ_ACC] = 1'b1;
                        end
                    end
                    else
                    begin
                        // low address bits are ignored
                        next_s.fail = 1'b0;
                        next_s.state = ST_RDOLD;
                        next_s.raddr = {s.addr[`FADDR_W-1:2], 2'b00};
                        next_s.arr_addr = {s.addr[`FADDR_W-1:2], 2'b00};
                    end
                end
                else if (erase_req)
                begin
                    if (erase_bad)
                    begin
                        next_s.fail = 1'b1;
                        if (erase_prot)
                        begin
                            next_s.ris[`IRQ_ACC] = 1'b1;
                        end
                    end
                    else
                    begin
                        next_s.fail = 1'b0;
                        next_s.state = ST_PULSE;
                        next_s.arr_addr = s.addr;
                        next_s.arr_erase = 1'b1;
                        next_s.tmr_start = 1'b1;
                        next_s.tmr_us = ERASE_TIME_US;
                    end
                end
            end
            ST_RDOLD:
            begin
                // and-ing with the old word keeps zeros, so rewrites are safe
                next_s.arr_wdata = s.data & arr_rdata_i;
                next_s.arr_prog = 1'b1;
                next_s.tmr_start = 1'b1;
                next_s.tmr_us = `PROG_TIME_US;
                next_s.state = ST_PULSE;
            end
            ST_PULSE:
            begin
                if (tmr_done)
                begin
                    next_s.arr_prog = 1'b0;
                    next_s.arr_erase = 1'b0;
                    next_s.state = ST_DONE;
                end
            end
            ST_DONE:
            begin
                next_s.ris[`IRQ_DONE] = 1'b1;
                next_s.state = ST_IDLE;
            end
        endcase

        next_s.irq = |(next_s.ris & next_s.im);
    end

    // state register; all protection comes back read/write
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            s <= '0;
            s.usec <= `USEC_RST;
        end
        else
        begin
            s <= next_s;
        end
    end

    // ==========================================================
    // outputs
    assign reg_rdata_o = s.rdata;
    assign rd_valid_o = s.rd_valid;
    assign rd_err_o = s.rd_err;
    assign rd_data_o = s.rd_data;
    assign arr_raddr_o = s.raddr;
    assign arr_addr_o = s.arr_addr;
    assign arr_wdata_o = s.arr_wdata;
    assign arr_prog_o = s.arr_prog;
    assign arr_erase_o = s.arr_erase;
    assign busy_o = (s.state != ST_IDLE);
    assign irq_o = s.irq;

    // ==========================================================
    // checks
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (srst_i);

    sequence s_prog_start;
        prog_go;
    endsequence

    sequence s_prog_pulse;
        (s.state == ST_RDOLD) ##1 ((s.state == ST_PULSE) && arr_prog_o);
    endsequence

    sequence s_finish;
        (s.state == ST_DONE) ##1 (s.ris[`IRQ_DONE] && !busy_o);
    endsequence

    a_prog_starts: assert property
        (s_prog_start |=> s_prog_pulse)
        else $error("program did not start its pulse");
    a_prog_and_mask: assert property
        ((s.state == ST_RDOLD) |=>
            (arr_wdata_o == ($past(s.data) & $past(arr_rdata_i))))
        else $error("programmed word sets a zero bit");
    a_ro_refused: assert property
        ((s.state == ST_IDLE) && prog_req && (cmd_prot != PROT_RW)
            |=> !busy_o && s.fail && s.ris[`IRQ_ACC])
        else $error("program of protected region not refused");
    a_xo_data_block: assert property
        (rd_take && (rd_kind_i != ACC_FETCH) && (take_prot == PROT_XO)
            |-> ##2 (rd_valid_o && rd_err_o && (rd_data_o == '0)))
        else $error("data read of execute-only region served");
    a_fetch_served: assert property
        (rd_take && (rd_kind_i == ACC_FETCH) && in_range(rd_addr_i)
            |-> ##2 (rd_valid_o && !rd_err_o))
        else $error("fetch refused");
    a_viol_flag: assert property
        (rd_valid_o && rd_err_o |-> s.ris[`IRQ_ACC])
        else $error("violation source not raised");
    a_done_flag: assert property
        ((s.state == ST_PULSE) && tmr_done |=> s_finish)
        else $error("completion source not raised");
    a_irq_gate: assert property
        (irq_o == |(s.ris & s.im))
        else $error("interrupt line disagrees with masked status");
    a_xo_frozen: assert property
        (reg_we_i && (reg_addr_i == `REG_PROT) && (cmd_prot == PROT_XO)
            |=> (cmd_prot == PROT_XO))
        else $error("execute-only protection was loosened");
    a_clear_src: assert property
        (reg_we_i && (reg_addr_i == `REG_ICR) && reg_wdata_i[`IRQ_DONE]
            && (s.state != ST_DONE) |=> !s.ris[`IRQ_DONE])
        else $error("cleared source still set");
    a_busy_hold: assert property
        (busy_o && (prog_req || erase_req) |=> $stable(arr_addr_o)
            && (s.state != ST_RDOLD) && !$rose(arr_erase_o))
        else $error("command accepted while busy");

endmodule : fprot_ctrl

/* File: fprot_ctrl_tb.sv */
// self-checking testbench of the flash controller
`timescale 1ns/1ns
`include "fprot_defs.svh"

module fprot_ctrl_tb
    import fprot_pkg::*;
;
    logic clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic [7:0] reg_addr_i = 8'h00;
    logic [31:0] reg_wdata_i = 32'h0000_0000;
    logic reg_we_i = 1'b0;
    logic reg_re_i = 1'b0;
    logic [31:0] reg_rdata_o;
    logic rd_req_i = 1'b0;
    logic [1:0] rd_kind_i = 2'h0;
    logic [`FADDR_W-1:0] rd_addr_i = '0;
    logic rd_ready_o, rd_valid_o, rd_err_o, arr_prog_o, arr_erase_o;
    logic [31:0] rd_data_o, arr_rdata_i, arr_wdata_o;
    logic [`FADDR_W-1:0] arr_raddr_o, arr_addr_o;
    logic busy_o, irq_o, short_pulse;
    int errors = 0;
    int n_compared = 0;

    // ==========================================================
    // design and array, 8 KB so the range check is reachable
    fprot_ctrl #(.FLASH_KB(8), .BLOCK_KB(1), .ERASE_TIME_US(16'h0002)) dut
    (
        .clk_i(clk_i), .srst_i(srst_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i),
        .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o),
        .rd_req_i(rd_req_i), .rd_kind_i(rd_kind_i), .rd_addr_i(rd_addr_i),
        .rd_ready_o(rd_ready_o), .rd_valid_o(rd_valid_o),
        .rd_err_o(rd_err_o), .rd_data_o(rd_data_o),
        .arr_raddr_o(arr_raddr_o), .arr_rdata_i(arr_rdata_i),
        .arr_addr_o(arr_addr_o), .arr_wdata_o(arr_wdata_o),
        .arr_prog_o(arr_prog_o), .arr_erase_o(arr_erase_o),
        .busy_o(busy_o), .irq_o(irq_o)
    );

    fprot_array_model flash
    (
        .clk_i(clk_i), .raddr_i(arr_raddr_o), .rdata_o(arr_rdata_i),
        .addr_i(arr_addr_o), .wdata_i(arr_wdata_o), .prog_i(arr_prog_o),
        .erase_i(arr_erase_o), .short_o(short_pulse)
    );

    // clock
    always #5 clk_i = ~clk_i;

    // ==========================================================
    // tasks
    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic test_done();
        if (errors == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : test_done

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        reg_we_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge clk_i);
        reg_we_i <= 1'b0;
    endtask : wr

    // read data stand only in the cycle after the strobe
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp,
                        input string what);
        @(posedge clk_i);
        reg_re_i <= 1'b1;
        reg_addr_i <= a;
        @(posedge clk_i);
        reg_re_i <= 1'b0;
        #1 check(what, reg_rdata_o, exp);
    endtask : rchk

    // bounded wait, generous against a program pulse at one cycle per us
    task automatic wait_idle();
        #1;
        for (int i = 0; i < 100 && busy_o !== 1'b0; i++)
            @(posedge clk_i) #1;
        check("busy after command", busy_o, 0);
    endtask : wait_idle

    task automatic cmd(input logic [31:0] a, input logic [31:0] c);
        wr(`REG_ADDR, a);
        wr(`REG_CMD, c);
        wait_idle();
    endtask : cmd

    // request held until taken, answer one edge after the taking edge
    task automatic core(input acc_t k, input logic [31:0] a,
                        input logic e, input logic [31:0] d, input string s);
        @(posedge clk_i);
        rd_req_i <= 1'b1;
        rd_kind_i <= k;
        rd_addr_i <= a[`FADDR_W-1:0];
        #1;
        for (int i = 0; i < 20 && rd_ready_o !== 1'b1; i++)
            @(posedge clk_i) #1;
        @(posedge clk_i);
        rd_req_i <= 1'b0;
        @(posedge clk_i) #1;
        check({s, " valid"}, rd_valid_o, 1);
        check({s, " err"}, rd_err_o, e);
        check({s, " data"}, rd_data_o, d);
    endtask : core

    // ==========================================================
    // watchdog, far beyond the few hundred cycles of the tests
    initial
    begin
        #200000;
        errors++;
        test_done();
    end

    // main sequence
    initial
    begin
        repeat (5) @(posedge clk_i);
        srst_i <= 1'b0;
        rchk(`REG_RIS, 0, "ris at reset");
        rchk(`REG_USEC, `USEC_RST, "usec at reset");
        rchk(`REG_PROT, PROT_RW, "prot at reset");
        wr(`REG_USEC, 1);
        wr(`REG_IM, 3);
        cmd(32'h0000_0800, 2);
        rchk(`REG_CMD, 0, "erase ok");
        core(ACC_DATA, 32'h0000_0800, 0, 32'hffff_ffff, "first");
        core(ACC_DATA, 32'h0000_0bfc, 0, 32'hffff_ffff, "last");
        core(ACC_DATA, 32'h0000_0c00, 0, 0, "next block");
        rchk(`REG_RIS, 2, "ris done");
        check("irq done", irq_o, 1);
        wr(`REG_ICR, 2);
        rchk(`REG_RIS, 0, "ris cleared");
        check("irq cleared", irq_o, 0);
        wr(`REG_DATA, 32'h1234_5678);
        cmd(32'h0000_0800, 1);
        core(ACC_DATA, 32'h0000_0800, 0, 32'h1234_5678, "prog");
        wr(`REG_DATA, 32'h0000_ffff);
        wr(`REG_IM, 1);
        cmd(32'h0000_0800, 1);
        core(ACC_DATA, 32'h0000_0800, 0, 32'h0000_5678, "reprog");
        rchk(`REG_RIS, 2, "ris masked done");
        rchk(`REG_MIS, 0, "mis masked done");
        check("irq masked", irq_o, 0);
        wr(`REG_ICR, 2);
        // read-only region: changes refused, reads and fetches served
        wr(`REG_PROT, PROT_RO);
        rchk(`REG_PROT, PROT_RO, "prot ro");
        wr(`REG_DATA, 0);
        cmd(32'h0000_0800, 1);
        rchk(`REG_CMD, 2, "prog ro fails");
        rchk(`REG_RIS, 1, "ris prog ro");
        check("irq access", irq_o, 1);
        wr(`REG_ICR, 1);
        cmd(32'h0000_0c00, 2);
        rchk(`REG_CMD, 2, "erase ro pair fails");
        rchk(`REG_RIS, 1, "ris erase ro");
        core(ACC_DATA, 32'h0000_0800, 0, 32'h0000_5678, "ro data");
        core(ACC_FETCH, 32'h0000_0bfc, 0, 32'hffff_ffff, "ro fetch");
        wr(`REG_PROT, PROT_RW);
        rchk(`REG_PROT, PROT_RO, "no widening");
        // execute-only region: fetches only
        wr(`REG_PROT, PROT_XO);
        rchk(`REG_PROT, PROT_XO, "prot xo");
        wr(`REG_ICR, 1);
        core(ACC_DATA, 32'h0000_0800, 1, 0, "xo data");
        rchk(`REG_RIS, 1, "ris xo read");
        core(ACC_DEBUG, 32'h0000_0800, 1, 0, "xo debug");
        core(ACC_FETCH, 32'h0000_0800, 0, 32'h0000_5678, "xo fetch");
        wr(`REG_PROT, PROT_RO);
        rchk(`REG_PROT, PROT_XO, "xo fixed");
        wr(`REG_ICR, 3);
        // misaligned erase and reads past the array
        cmd(32'h0000_1004, 2);
        rchk(`REG_CMD, 2, "misaligned erase");
        wr(`REG_PROT, 3);
        rchk(`REG_PROT, PROT_RW, "code three refused");
        core(ACC_FETCH, 32'h0000_2000, 1, 0, "past end");
        // a command while busy is dropped
        cmd(32'h0000_1000, 2);
        wr(`REG_DATA, 32'ha5a5_a5a5);
        wr(`REG_CMD, 1);
        #1 check("busy", busy_o, 1);
        wr(`REG_CMD, 2);
        wait_idle();
        core(ACC_DATA, 32'h0000_1000, 0, 32'ha5a5_a5a5, "dropped");
        check("pulse length", short_pulse, 0);
        // a reset in mid-run drops protection and the rate to defaults
        @(posedge clk_i);
        srst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        srst_i <= 1'b0;
        wr(`REG_ADDR, 32'h0000_0800);
        rchk(`REG_PROT, PROT_RW, "prot after reset");
        rchk(`REG_USEC, `USEC_RST, "usec after reset");
        test_done();
    end
endmodule : fprot_ctrl_tb

/* File: fprot_defs.svh */
// offsets, field positions, reset values and timing of the flash controller
`ifndef FPROT_DEFS_SVH
`define FPROT_DEFS_SVH

// ==========================================================
// array geometry
`define FADDR_W 19
`define REGION_SHIFT 11
`define REGION_W 8
`define REGION_CNT 256
`define FLASH_KB_DEF 512
`define BLOCK_KB_DEF 1

// ==========================================================
// register offsets (byte addresses on the register port)
`define REG_ADDR 8'h00
`define REG_DATA 8'h04
`define REG_CMD 8'h08
`define REG_PROT 8'h0c
`define REG_USEC 8'h10
`define REG_RIS 8'h14
`define REG_IM 8'h18
`define REG_MIS 8'h1c
`define REG_ICR 8'h20

// ==========================================================
// field positions
`define CMD_PROG 0
`define CMD_ERASE 1
`define STAT_BUSY 0
`define STAT_FAIL 1
`define IRQ_ACC 0
`define IRQ_DONE 1

// ==========================================================
// timing; cycles follow from the cycles-per-microsecond register
`define CLK_PERIOD_NS 10
`define NS_PER_US 1000
`define USEC_RST (8'((`NS_PER_US) / (`CLK_PERIOD_NS)))
`define PROG_TIME_US 16'h0014
`define ERASE_TIME_US_DEF 16'h03e8

`endif

/* File: fprot_pkg.sv */
// types shared by the flash controller modules
package fprot_pkg;

`include "fprot_defs.svh"

    // ==========================================================
    // protection levels, ordered from loose to strict
    typedef enum logic [1:0]
    {
        PROT_RW = 2'b00,
        PROT_RO = 2'b01,
        PROT_XO = 2'b10
    } prot_t;

    // kind of a core read
    typedef enum logic [1:0]
    {
        ACC_FETCH = 2'b00,
        ACC_DATA = 2'b01,
        ACC_DEBUG = 2'b10
    } acc_t;

    // sequencer states, gray along idle-read-pulse-done
    typedef enum logic [1:0]
    {
        ST_IDLE = 2'b00,
        ST_RDOLD = 2'b01,
        ST_PULSE = 2'b11,
        ST_DONE = 2'b10
    } seq_t;

    // ==========================================================
    // controller state
    typedef struct packed {
        seq_t state;
        logic [`FADDR_W-1:0] addr;
        logic [31:0] data;
        logic [7:0] usec;
        logic [1:0] ris;
        logic [1:0] im;
        logic fail;
        logic irq;
        logic [31:0] rdata;
        logic [`FADDR_W-1:0] arr_addr;
        logic [31:0] arr_wdata;
        logic arr_prog;
        logic arr_erase;
        logic tmr_start;
        logic [15:0] tmr_us;
        logic [`FADDR_W-1:0] raddr;
        logic [1:0] rkind;
        logic rpend;
        logic rd_valid;
        logic rd_err;
        logic [31:0] rd_data;
        prot_t [`REGION_CNT-1:0] prot;
    } ctrl_t;

    // microsecond timer state
    typedef struct packed {
        logic active;
        logic [7:0] cyc;
        logic [15:0] us;
        logic done;
    } tmr_t;

endpackage : fprot_pkg

/* File: fprot_us_timer.sv */
// microsecond pulse timer for the flash array strobes
`timescale 1ns/1ns
`include "fprot_defs.svh"

module fprot_us_timer
    import fprot_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic srst_i,
    // request
    input wire logic start_i,
    input wire logic [7:0] cyc_per_us_i,
    input wire logic [15:0] us_i,
    // result
    output logic done_o
);

    tmr_t t;
    tmr_t next_t;
    logic [7:0] lim;

    // ==========================================================
    // count whole microseconds; a zero rate counts as one cycle
    always_comb
    begin
        next_t = t;
        next_t.done = 1'b0;
        lim = (cyc_per_us_i == 8'h00) ? 8'h01 : cyc_per_us_i;
        if (start_i)
        begin
            next_t.active = 1'b1;
            next_t.cyc = 8'h00;
            next_t.us = (us_i == 16'h0000) ? 16'h0001 : us_i;
        end
        else if (t.active)
        begin
            if (t.cyc + 8'h01 >= lim)
            begin
                next_t.cyc = 8'h00;
                if (t.us == 16'h0001)
                begin
                    next_t.active = 1'b0;
                    next_t.done = 1'b1;
                end
                else
                begin
                    next_t.us = t.us - 16'h0001;
                end
            end
            else
            begin
                next_t.cyc = t.cyc + 8'h01;
            end
        end
    end

    // state register
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            t <= '0;
        end
        else
        begin
            t <= next_t;
        end
    end

    assign done_o = t.done;

endmodule : fprot_us_timer
